/* File: dv/motion_ctrl_model.sv */
// network controller model: issues object reads and writes.
// assumes the caller runs one request at a time on ref_clk.
`default_nettype none
module motion_ctrl_model (
  // clock
  input wire logic ref_clk,
  // object access
  output logic obj_rd,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [7:0] obj_sub,
  output logic [31:0] obj_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // request driver
  // ----------------------------------------
  initial begin
    {obj_rd, obj_wr, obj_index, obj_sub, obj_wdata} = '0;
  end
  // write carries the probe control, reads fetch objects
  task automatic req(input logic w, input logic [15:0] idx,
                     input logic [7:0] sub, input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    obj_index = idx;
    obj_sub = sub;
    obj_wdata = d;
    obj_rd = !w;
    obj_wr = w;
    @(posedge ref_clk);
    #1;
    obj_rd = 1'b0;
    obj_wr = 1'b0;
    // released address and data no longer hold the old value
    obj_index = ~idx;
    obj_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: dv/scale_probe_latch_tb.sv */
// self-checking bench for the scale readout and probe latch.
// assumes the controller model and a 50 MHz ref_clk.
`default_nettype none
module scale_probe_latch_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_b, obj_rd, obj_wr, scale_enabled, scale_abs_sys;
  logic scale_valid, scale_delta_valid, motor_abs_sys;
  logic precise_probe_select, enc_pulse_enable;
  logic first_probe_input, second_probe_input;
  logic [15:0] obj_index, scale_alarm;
  logic [7:0] obj_sub;
  logic [31:0] obj_wdata, obj_rdata, scale_cycle_raw, scale_turns_raw;
  logic [31:0] scale_res_raw, scale_delta, position_fb, c, t, r, p, q;
  probe_scale_pkg::scale_kind_t scale_kind;
  logic [31:0] exp_q[$];
  logic rd_d = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  // ----------------------------------------
  // clock, controller, design
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  motion_ctrl_model ctrl (.ref_clk, .obj_rd, .obj_wr, .obj_index,
    .obj_sub, .obj_wdata);
  scale_probe_latch #(.SLOW_CYCLES(4), .FAST_CYCLES(2)) uut (
    .ref_clk, .rst_b, .obj_rd, .obj_wr, .obj_index, .obj_sub,
    .obj_wdata, .obj_rdata, .scale_enabled, .scale_abs_sys,
    .scale_kind, .scale_valid, .scale_cycle_raw, .scale_turns_raw,
    .scale_res_raw, .scale_alarm, .scale_delta, .scale_delta_valid,
    .motor_abs_sys, .first_probe_input, .second_probe_input,
    .precise_probe_select, .position_fb, .enc_pulse_enable);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s,
                    input logic [31:0] e);
    exp_q.push_back(e);
    ctrl.req(1'b0, i, s, 32'h0000_0000);
  endtask
  task automatic wr(input logic [15:0] v);
    ctrl.req(1'b1, 16'h60b8, 8'h00, {16'h0000, v});
  endtask
  task automatic scale(input logic [31:0] a, b, e);
    @(posedge ref_clk);
    #1;
    {scale_cycle_raw, scale_turns_raw, scale_res_raw} = {a, b, e};
    scale_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    scale_valid = 1'b0;
  endtask
  task automatic delta(input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    scale_delta = d;
    scale_delta_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    scale_delta_valid = 1'b0;
  endtask
  // level held far longer than the shortened tick
  task automatic pin(input logic two, lvl, input logic [31:0] pos);
    @(posedge ref_clk);
    #1;
    position_fb = pos;
    if (two) second_probe_input = lvl;
    else first_probe_input = lvl;
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // read monitor and watchdog
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rd_d) check(obj_rdata, exp_q.pop_front());
    rd_d <= obj_rd;
  end
  initial begin
    #200000;
    err_total++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(49421));
    {rst_b, scale_enabled, scale_abs_sys, scale_valid, scale_alarm} = '0;
    {scale_cycle_raw, scale_turns_raw, scale_res_raw, scale_delta} = '0;
    {scale_delta_valid, motor_abs_sys, precise_probe_select} = '0;
    {first_probe_input, second_probe_input, position_fb} = '0;
    scale_kind = probe_scale_pkg::enc_rotary;
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    rd(16'h60b9, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++)
      rd(16'h60ba + 16'(i), 8'h00, 32'h0);
    rd(16'h2d35, 8'h00, 32'h1);
    rd(16'h1234, 8'h00, 32'h0);
    motor_abs_sys = 1'b1;
    rd(16'h2d35, 8'h01, 32'h1);
    c = $urandom;
    t = $urandom;
    r = $urandom;
    scale(c, t, r);
    rd(16'h2d36, 8'h00, 32'h0);
    {scale_enabled, scale_abs_sys} = 2'b11;
    scale(c, t, r);
    rd(16'h2d36, 8'h00, c);
    rd(16'h2d37, 8'h00, t);
    rd(16'h2d38, 8'h00, r);
    scale_alarm = 16'($urandom) | 16'h0001;
    scale(~c, ~t, ~r);
    rd(16'h2d36, 8'h00, c);
    rd(16'h2d3c, 8'h00, {16'h0000, scale_alarm});
    scale_alarm = 16'h0000;
    scale_kind = probe_scale_pkg::enc_linear_abs;
    scale(~c, ~t, ~r);
    rd(16'h2d36, 8'h00, ~c);
    rd(16'h2d37, 8'h00, 32'h0);
    rd(16'h2d38, 8'h00, 32'h0);
    rd(16'h2d35, 8'h02, 32'h7);
    scale_kind = probe_scale_pkg::enc_linear_inc;
    delta(c);
    delta(32'hffff_fffb);
    // raw words ignored: incremental scale shows the coasting count
    scale(~c, ~t, ~r);
    rd(16'h2d36, 8'h00, c - 32'h5);
    scale_kind = probe_scale_pkg::enc_linear_abz;
    rd(16'h2d36, 8'h00, c - 32'h5);
    wr(16'h0031);
    rd(16'h60b9, 8'h00, 32'h1);
    p = $urandom;
    q = $urandom;
    pin(1'b0, 1'b1, p);
    rd(16'h60b9, 8'h00, 32'h3);
    rd(16'h60ba, 8'h00, p);
    pin(1'b0, 1'b0, q);
    rd(16'h60b9, 8'h00, 32'h7);
    rd(16'h60bb, 8'h00, q);
    pin(1'b0, 1'b1, ~p);
    rd(16'h60ba, 8'h00, p);
    wr(16'h0021);
    rd(16'h60b9, 8'h00, 32'h5);
    wr(16'h0000);
    rd(16'h60b9, 8'h00, 32'h0);
    rd(16'h60ba, 8'h00, p);
    precise_probe_select = 1'b1;
    #1 check({31'h0, enc_pulse_enable}, 32'h0);
    wr(16'h3300);
    pin(1'b1, 1'b1, p);
    pin(1'b1, 1'b0, q);
    pin(1'b1, 1'b1, ~p);
    rd(16'h60bc, 8'h00, ~p);
    rd(16'h60bd, 8'h00, q);
    rd(16'h60b9, 8'h00, 32'h700);
    precise_probe_select = 1'b0;
    #1 check({31'h0, enc_pulse_enable}, 32'h1);
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule
`default_nettype wire

/* File: include/probe_scale_defines.svh */
// object indices, field positions, the entry count and timings for the
// scale readout and touch-probe latch block.
// assumes the includer wants plain macros; no code here.
// Behaviour
// - scale objects read zero unless scale enabled
// - cycle count source follows encoder type
// - turns count zero for every linear scale
// - nonzero alarm freezes stored scale values
// - resolution zero unless rotary scale
// - scale status bits: absolute, enabled, abs-type
// - motor status bit zero: absolute system
// - entry count is read-only, value one
// - coasting counter signed 32-bit from zero
// - latch position on both edges of both probes
// - normal mode: 55 us edge granularity
// - precise mode: probe two rising at 2 us
// - precise probing stops encoder pulse output
// - control word is 16-bit read-write
// - probe state word read-only, resets zero
// - four latched positions signed, reset zero
// - control bits 0,1,4,5 and 8,9,12,13
// - state bits 0-2 and 8-10 per probe
// - disabling clears flags; positions kept
`ifndef PROBE_SCALE_DEFINES_SVH
`define PROBE_SCALE_DEFINES_SVH

// ----------------------------------------------------------------
// object indices
// ----------------------------------------------------------------
`define IDX_ENC_STATUS 16'h2d35
`define IDX_CYCLE 16'h2d36
`define IDX_TURNS 16'h2d37
`define IDX_RES 16'h2d38
`define IDX_ALARM 16'h2d3c
`define IDX_PCTL 16'h60b8
`define IDX_PSTAT 16'h60b9
`define IDX_P1R 16'h60ba
`define IDX_P1F 16'h60bb
`define IDX_P2R 16'h60bc
`define IDX_P2F 16'h60bd
`define SUB_COUNT 8'h00
`define SUB_MOTOR 8'h01
`define SUB_SCALE 8'h02
`define ENTRY_COUNT 8'h01

// ----------------------------------------------------------------
// control and state fields (probe two adds PROBE_OFS)
// ----------------------------------------------------------------
`define PROBE_OFS 8
`define CTL_EN 0
`define CTL_CONT 1
`define CTL_RISE 4
`define CTL_FALL 5
`define ST_EN 0
`define ST_RISE 1
`define ST_FALL 2
`define SST_ABS_SYS 0
`define SST_ENABLED 1
`define SST_ABS_TYPE 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 50
`define SLOW_TICK_NS 55000
`define FAST_TICK_NS 2000
`define SLOW_CYC (`SLOW_TICK_NS * `CLK_MHZ / 1000)
`define FAST_CYC (`FAST_TICK_NS * `CLK_MHZ / 1000)

`endif

/* File: include/probe_scale_pkg.sv */
// types shared by the scale readout and touch-probe latch.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package probe_scale_pkg;
  typedef enum logic [1:0] {
    enc_rotary,
    enc_linear_abs,
    enc_linear_inc,
    enc_linear_abz
  } scale_kind_t;
endpackage
`default_nettype wire

/* File: verilog/scale_probe_latch.sv */
// scale readout objects and touch-probe position latch.
// assumes scale inputs come from logic on ref_clk; probe pins are
// asynchronous and are synchronised here.
`include "probe_scale_defines.svh"
`default_nettype none
module scale_probe_latch #(
  parameter int SLOW_CYCLES = `SLOW_CYC,
  parameter int FAST_CYCLES = `FAST_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // object access
  input wire logic obj_rd,
  input wire logic obj_wr,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  // scale encoder side
  input wire logic scale_enabled,
  input wire logic scale_abs_sys,
  input wire probe_scale_pkg::scale_kind_t scale_kind,
  input wire logic scale_valid,
  input wire logic [31:0] scale_cycle_raw,
  input wire logic [31:0] scale_turns_raw,
  input wire logic [31:0] scale_res_raw,
  input wire logic [15:0] scale_alarm,
  input wire logic [31:0] scale_delta,
  input wire logic scale_delta_valid,
  input wire logic motor_abs_sys,
  // touch probe
  input wire logic first_probe_input,
  input wire logic second_probe_input,
  input wire logic precise_probe_select,
  input wire logic [31:0] position_fb,
  output logic enc_pulse_enable
);

  // ----------------------------------------------------------------
  // probe synchronisers and sample ticks
  // ----------------------------------------------------------------
  logic [1:0] sy1_q, sy2_q, sy1_d, sy2_d;
  // bit 2: probe two level as seen on the slow grid
  logic [2:0] lvl_q, lvl_d;
  logic [15:0] slow_q, slow_d, fast_q, fast_d;
  logic slow_tick, fast_tick;

  always_comb begin
    sy1_d = {second_probe_input, first_probe_input};
    sy2_d = sy1_q;
    slow_tick = (slow_q == 16'(SLOW_CYCLES - 1));
    fast_tick = (fast_q == 16'(FAST_CYCLES - 1));
    slow_d = slow_tick ? 16'h0000 : slow_q + 16'h0001;
    fast_d = fast_tick ? 16'h0000 : fast_q + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_q <= 2'h0;
      sy2_q <= 2'h0;
      slow_q <= 16'h0000;
      fast_q <= 16'h0000;
    end else begin
      sy1_q <= sy1_d;
      sy2_q <= sy2_d;
      slow_q <= slow_d;
      fast_q <= fast_d;
    end
  end

  // ----------------------------------------------------------------
  // control word, state word and latched positions
  // ----------------------------------------------------------------
  logic [15:0] ctl_q, ctl_d, st_q, st_d;
  logic [31:0] pos_q [4];
  logic [31:0] pos_d [4];
  logic [1:0] rise_ev, fall_ev;
  logic ctl_wr;

  assign ctl_wr = obj_wr && obj_index == `IDX_PCTL && obj_sub == `SUB_COUNT;

  always_comb begin
    int b;
    b = 0;
    lvl_d = lvl_q;
    rise_ev = 2'h0;
    fall_ev = 2'h0;
    // probe one and probe two falling: 55 us grid
    // probe two rising: 2 us grid when precise
    // probe two falling keeps its own level, so fast samples
    // in between cannot swallow a falling edge
    if (slow_tick) begin
      lvl_d[0] = sy2_q[0];
      lvl_d[2] = sy2_q[1];
      rise_ev[0] = sy2_q[0] && !lvl_q[0];
      fall_ev[0] = !sy2_q[0] && lvl_q[0];
      fall_ev[1] = !sy2_q[1] && lvl_q[2];
    end
    if (precise_probe_select ? fast_tick : slow_tick) begin
      lvl_d[1] = sy2_q[1];
      rise_ev[1] = sy2_q[1] && !lvl_q[1];
    end
    ctl_d = ctl_wr ? obj_wdata[15:0] : ctl_q;
    st_d = st_q;
    pos_d = pos_q;
    for (int p = 0; p < 2; p++) begin
      b = p * `PROBE_OFS;
      st_d[b + `ST_EN] = ctl_q[b + `CTL_EN];
      if (ctl_q[b + `CTL_EN]) begin
        // single mode keeps the first edge until re-armed
        if (rise_ev[p] && ctl_q[b + `CTL_RISE] &&
            (ctl_q[b + `CTL_CONT] || !st_q[b + `ST_RISE])) begin
          st_d[b + `ST_RISE] = 1'b1;
          pos_d[2 * p] = position_fb;
        end
        if (fall_ev[p] && ctl_q[b + `CTL_FALL] &&
            (ctl_q[b + `CTL_CONT] || !st_q[b + `ST_FALL])) begin
          st_d[b + `ST_FALL] = 1'b1;
          pos_d[2 * p + 1] = position_fb;
        end
        if (!ctl_q[b + `CTL_RISE]) st_d[b + `ST_RISE] = 1'b0;
        if (!ctl_q[b + `CTL_FALL]) st_d[b + `ST_FALL] = 1'b0;
      end else begin
        st_d[b + `ST_RISE] = 1'b0;
        st_d[b + `ST_FALL] = 1'b0;
      end
    end
    st_d[7:3] = 5'h00;
    st_d[15:11] = 5'h00;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_q <= 3'h0;
      ctl_q <= 16'h0000;
      st_q <= 16'h0000;
      for (int i = 0; i < 4; i++) pos_q[i] <= 32'h0000_0000;
    end else begin
      lvl_q <= lvl_d;
      ctl_q <= ctl_d;
      st_q <= st_d;
      pos_q <= pos_d;
    end
  end

  assign enc_pulse_enable = !precise_probe_select;

  // ----------------------------------------------------------------
  // scale objects
  // ----------------------------------------------------------------
  logic [31:0] coast_q, coast_d, cyc_q, cyc_d, trn_q, trn_d, res_q, res_d;
  logic rotary, linear_inc;

  always_comb begin
    rotary = (scale_kind == probe_scale_pkg::enc_rotary);
    linear_inc = (scale_kind == probe_scale_pkg::enc_linear_inc) ||
                 (scale_kind == probe_scale_pkg::enc_linear_abz);
    // signed wraps over the full 32-bit range
    coast_d = scale_delta_valid ? coast_q + scale_delta : coast_q;
    cyc_d = cyc_q;
    trn_d = trn_q;
    res_d = res_q;
    if (scale_valid && scale_alarm == 16'h0000) begin
      cyc_d = linear_inc ? coast_d : scale_cycle_raw;
      trn_d = rotary ? scale_turns_raw : 32'h0000_0000;
      res_d = rotary ? scale_res_raw : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      coast_q <= 32'h0000_0000;
      cyc_q <= 32'h0000_0000;
      trn_q <= 32'h0000_0000;
      res_q <= 32'h0000_0000;
    end else begin
      coast_q <= coast_d;
      cyc_q <= cyc_d;
      trn_q <= trn_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_d, rd_q, scale_st;

  // scale objects read zero while the scale is off
  function automatic logic [31:0] gate_scale(input logic en,
                                             input logic [31:0] v);
    return en ? v : 32'h0000_0000;
  endfunction

  always_comb begin
    scale_st = 32'h0000_0000;
    scale_st[`SST_ABS_SYS] = scale_abs_sys;
    scale_st[`SST_ENABLED] = scale_enabled;
    scale_st[`SST_ABS_TYPE] = scale_kind == probe_scale_pkg::enc_linear_abs;
    rd_d = rd_q;
    if (obj_rd) begin
      rd_d = 32'h0000_0000;
      case (obj_index)
        `IDX_ENC_STATUS: begin
          if (obj_sub == `SUB_COUNT) rd_d = {24'h0, `ENTRY_COUNT};
          else if (obj_sub == `SUB_MOTOR)
            rd_d = {31'h0, motor_abs_sys};
          else if (obj_sub == `SUB_SCALE) rd_d = scale_st;
        end
        // zero while scale disabled
        `IDX_CYCLE: rd_d = gate_scale(scale_enabled, cyc_q);
        `IDX_TURNS: rd_d = gate_scale(scale_enabled, trn_q);
        `IDX_RES: rd_d = gate_scale(scale_enabled, res_q);
        `IDX_ALARM: rd_d = gate_scale(scale_enabled, {16'h0, scale_alarm});
        `IDX_PCTL: rd_d = {16'h0, ctl_q};
        `IDX_PSTAT: rd_d = {16'h0, st_q};
        `IDX_P1R: rd_d = pos_q[0];
        `IDX_P1F: rd_d = pos_q[1];
        `IDX_P2R: rd_d = pos_q[2];
        `IDX_P2F: rd_d = pos_q[3];
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) rd_q <= 32'h0000_0000;
    else rd_q <= rd_d;
  end

  assign obj_rdata = rd_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_disable_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ctl_q[`CTL_EN] |=> st_q[2:0] == 3'h0)
    else $error("probe one flags not cleared when disabled");
  a_rise_latch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ctl_q[`CTL_EN] && ctl_q[`CTL_RISE] && rise_ev[0] &&
    (ctl_q[`CTL_CONT] || !st_q[`ST_RISE])
    |=> st_q[`ST_RISE] && pos_q[0] == $past(position_fb))
    else $error("probe one rising edge not latched");
  a_single_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q[`ST_RISE] && !ctl_q[`CTL_CONT] |=> $stable(pos_q[0]))
    else $error("single mode overwrote latched position");
  a_alarm_freeze: assert property (@(posedge ref_clk) disable iff (!rst_b)
    scale_alarm != 16'h0000 |=> $stable(cyc_q) && $stable(trn_q))
    else $error("scale values changed during alarm");
  a_linear_turns: assert property (@(posedge ref_clk) disable iff (!rst_b)
    scale_valid && scale_alarm == 16'h0000 && !rotary
    |=> trn_q == 32'h0 && res_q == 32'h0)
    else $error("linear scale shows turns or resolution");
  a_disabled_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    obj_rd && !scale_enabled && obj_index == `IDX_CYCLE
    |=> obj_rdata == 32'h0)
    else $error("cycle count read nonzero while disabled");
  a_pulse_stop: assert property (@(posedge ref_clk) disable iff (!rst_b)
    precise_probe_select |-> !enc_pulse_enable)
    else $error("encoder pulses left on in precise mode");
  a_slow_grid: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rise_ev[0] || fall_ev[0] |-> slow_tick)
    else $error("probe one edge off the slow grid");
  a_two_slow_rise: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !precise_probe_select && rise_ev[1] |-> slow_tick)
    else $error("probe two rise off the slow grid");
  a_two_fast_rise: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    precise_probe_select && rise_ev[1] |-> fast_tick)
    else $error("probe two precise rise off the fast grid");
  a_two_slow_fall: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    fall_ev[1] |-> slow_tick)
    else $error("probe two fall off the slow grid");
  a_fall_latch: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctl_q[`CTL_EN] && ctl_q[`CTL_FALL] && fall_ev[0] &&
    (ctl_q[`CTL_CONT] || !st_q[`ST_FALL])
    |=> st_q[`ST_FALL] && pos_q[1] == $past(position_fb))
    else $error("probe one falling edge not latched");
  a_two_rise_latch: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctl_q[8] && ctl_q[12] && rise_ev[1] && (ctl_q[9] || !st_q[9])
    |=> st_q[9] && pos_q[2] == $past(position_fb))
    else $error("probe two rising edge not latched");
  a_two_fall_latch: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctl_q[8] && ctl_q[13] && fall_ev[1] && (ctl_q[9] || !st_q[10])
    |=> st_q[10] && pos_q[3] == $past(position_fb))
    else $error("probe two falling edge not latched");
  a_flag_mirror: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctl_q[`CTL_EN] |=> st_q[`ST_EN])
    else $error("probe one enable not mirrored");
  a_two_mirror: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctl_q[8] |=> st_q[8])
    else $error("probe two enable not mirrored");
  a_reserved_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_q[7:3] == 5'h00 && st_q[15:11] == 5'h00)
    else $error("reserved state bits set");
  a_two_clears: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !ctl_q[8] |=> st_q[10:8] == 3'h0)
    else $error("probe two flags not cleared when disabled");
  a_rise_clear: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !ctl_q[`CTL_RISE] |=> !st_q[`ST_RISE])
    else $error("rise flag kept with sampling off");
  a_ctl_write: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    ctl_wr |=> ctl_q == $past(obj_wdata[15:0]))
    else $error("control word write lost");
  a_coast_add: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    scale_delta_valid |=> coast_q == $past(coast_q) + $past(scale_delta))
    else $error("coasting counter did not add travel");
  a_inc_cycle: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    scale_valid && scale_alarm == 16'h0000 && linear_inc
    |=> cyc_q == $past(coast_d))
    else $error("incremental scale cycle count not coasting");
  a_rotary_turns: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    scale_valid && scale_alarm == 16'h0000 && rotary
    |=> trn_q == $past(scale_turns_raw))
    else $error("rotary turns count not taken");
  a_entry_count: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    obj_rd && obj_index == `IDX_ENC_STATUS && obj_sub == `SUB_COUNT
    |=> obj_rdata == {24'h0, `ENTRY_COUNT})
    else $error("entry count read wrong");
  a_state_read: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    obj_rd && obj_index == `IDX_PSTAT
    |=> obj_rdata == {16'h0, $past(st_q)})
    else $error("state word read wrong");
  a_scale_status: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    obj_rd && obj_index == `IDX_ENC_STATUS && obj_sub == `SUB_SCALE
    |=> obj_rdata[`SST_ENABLED] == $past(scale_enabled))
    else $error("scale status enable bit wrong");
  a_disabled_turns: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    obj_rd && !scale_enabled && obj_index == `IDX_TURNS
    |=> obj_rdata == 32'h0)
    else $error("turns count read nonzero while disabled");

endmodule
`default_nettype wire
